// ===== aop_cfg.svh
// Constants for the converter output port: offsets, field positions, codes and counts
`ifndef AOP_CFG_SVH
`define AOP_CFG_SVH

// Output word width and pipeline latency in sample clock cycles
`define AOP_WIDTH 14
`define AOP_LATENCY 6

// Raw level input width and full-scale limits of the signed level
`define AOP_LEVEL_WIDTH 16
`define AOP_FS_POS 16'sh1FFF
`define AOP_FS_NEG -16'sh2000

// Register byte offsets on the APB bus
`define AOP_ADDR_WIDTH 12
`define AOP_OFF_CTRL 12'h000
`define AOP_OFF_STATUS 12'h004
`define AOP_OFF_DATA 12'h008

// Control register fields and reset value
`define AOP_CTRL_PD_BIT 0
`define AOP_CTRL_RESET 1'h0

// Status register fields
`define AOP_ST_STATE_LSB 0
`define AOP_ST_TWOS_BIT 2
`define AOP_ST_STAB_BIT 3
`define AOP_ST_FLAG_BIT 4

// Data register fields
`define AOP_DATA_FLAG_BIT 16

// Four levels of the configuration pin as decoded codes
`define AOP_MODE_GND 2'h0
`define AOP_MODE_THIRD 2'h1
`define AOP_MODE_TWO_THIRDS 2'h2
`define AOP_MODE_SUPPLY 2'h3

`endif

// ===== aop_pkg.sv
// Types shared by the converter output port modules
`include "aop_cfg.svh"
package aop_pkg;
	// Operating state chosen by the power-down and output enable pins
	typedef enum logic [1:0] {
		AOP_NORMAL,
		AOP_NAP,
		AOP_SLEEP
	} aop_state_e;

	// One converted result as it leaves the pipeline
	typedef logic [`AOP_WIDTH-1:0] aop_word_t;

	// Raw signed level presented to the quantizer
	typedef logic signed [`AOP_LEVEL_WIDTH-1:0] aop_level_t;
endpackage

// ===== aop_pipe_if.sv
// Link between the converter control logic and its result pipeline
`timescale 1ns/1ns
interface aop_pipe_if;
	import aop_pkg::*;
	logic advance; // One pclk pulse per sample clock rising edge while in normal mode
	aop_word_t head_word; // Offset-binary result entering the pipeline
	logic head_flag; // Range flag entering the pipeline
	aop_word_t tail_word; // Result leaving the last stage
	logic tail_flag; // Range flag leaving the last stage

	// Control side feeds the head and reads the tail
	modport ctrl (output advance, output head_word, output head_flag,
		input tail_word, input tail_flag);
	// Pipeline side
	modport pipe (input advance, input head_word, input head_flag,
		output tail_word, output tail_flag);
endinterface

// ===== aop_pipe.sv
// Result pipeline: word and range flag delayed by a fixed number of sample edges
`timescale 1ns/1ns
`include "aop_cfg.svh"
module aop_pipe #(
	parameter int DEPTH = `AOP_LATENCY
) (
	input wire logic pclk,
	input wire logic presetn,
	aop_pipe_if.pipe link
);
	import aop_pkg::*;

	aop_word_t word [DEPTH]; // Stage words
	logic flag [DEPTH]; // Stage range flags
	aop_word_t next_word [DEPTH];
	logic next_flag [DEPTH];

	// One stage per pipelined converter step; all move together on a sample edge
	for (genvar i = 0; i < DEPTH; i++) begin : g_stage
		aop_word_t prev_word; // Value this stage takes on a sample edge
		logic prev_flag; // Flag this stage takes on a sample edge

		// Stage zero takes the fresh result, the rest take their neighbour;
		// chosen at elaboration so stage zero never names a stage below it
		if (i == 0) begin : g_head
			assign prev_word = link.head_word;
			assign prev_flag = link.head_flag;
		end else begin : g_body
			assign prev_word = word[i-1];
			assign prev_flag = flag[i-1];
		end

		// Hold unless the sample edge moves the whole pipe
		always_comb begin
			next_word[i] = word[i];
			next_flag[i] = flag[i];
			if (link.advance) begin // [RL2]
				next_word[i] = prev_word;
				next_flag[i] = prev_flag;
			end
		end

		// Stage registers
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				word[i] <= '0;
				flag[i] <= 1'b0;
			end else begin
				word[i] <= next_word[i];
				flag[i] <= next_flag[i];
			end
		end
	end

	assign link.tail_word = word[DEPTH-1];
	assign link.tail_flag = flag[DEPTH-1];
endmodule // aop_pipe

// ===== aop_port.sv
// Digital side of the 14-bit sampling converter: output port, mode pins, APB registers
//
// How it works
// RL1: new sample taken each sample clock rise
// RL2: result appears six sample cycles later
// RL3: normal mode; output enable low drives outputs
// RL4: power-down stops conversion; nap or sleep
// RL5: config pin picks format and stabilizer
// RL6: range flag high when beyond full scale
// RL7: fourteen-bit word, top bit most significant
// RL8: two's complement inverts offset-binary top bit
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "aop_cfg.svh"
module aop_port #(
	parameter int LATENCY = `AOP_LATENCY
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`AOP_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_clk,
	input wire aop_pkg::aop_level_t sample_level,
	input wire logic output_enable_n,
	input wire logic power_down_select,
	input wire logic [1:0] mode_level,
	output aop_pkg::aop_word_t sample_word_out,
	output logic sample_word_oe,
	output logic range_flag,
	output logic range_flag_oe,
	output logic duty_stabilizer_on
);
	import aop_pkg::*;

	localparam int SYNC_W = 5 + `AOP_LEVEL_WIDTH;

	// Pin synchronisers; first stage is read only by the second
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic clk_prev; // Previous synchronised sample clock level
	logic [SYNC_W-1:0] next_sync1;
	logic [SYNC_W-1:0] next_sync2;
	logic next_clk_prev;

	// Synchronised pin views
	logic s_clk;
	logic s_oe_n;
	logic s_pd;
	logic [1:0] s_mode;
	aop_level_t s_level;

	// Operating state and decoded configuration
	aop_state_e state;
	aop_state_e next_state;
	logic twos; // Output format is two's complement
	logic next_twos;
	logic next_stab;

	// Output registers
	aop_word_t next_word_out;
	logic next_word_oe;
	logic next_flag;
	logic next_flag_oe;

	// Software control bit and bus answer registers
	logic ctrl_pd; // Software forces power down
	logic next_ctrl_pd;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Quantizer outputs
	logic over_pos;
	logic over_neg;
	aop_word_t quant_word;
	logic sample_edge;

	aop_pipe_if link ();

	aop_pipe #(
		.DEPTH(LATENCY)
	) u_pipe (
		.pclk(pclk),
		.presetn(presetn),
		.link(link)
	);

	// Pins come from outside pclk, so all pass two flops first
	always_comb begin
		next_sync1 = {sample_clk, output_enable_n, power_down_select, mode_level, sample_level};
		next_sync2 = sync1;
		next_clk_prev = s_clk;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			clk_prev <= 1'b0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			clk_prev <= next_clk_prev;
		end
	end

	assign {s_clk, s_oe_n, s_pd, s_mode, s_level} = sync2;

	// A rising sample clock while converting starts a new sample
	assign sample_edge = s_clk && !clk_prev && (state == AOP_NORMAL); // [RL1] [RL4]

	// Clamp the level to full scale and flag the excess
	assign over_pos = (s_level > `AOP_FS_POS); // [RL6]
	assign over_neg = (s_level < `AOP_FS_NEG); // [RL6]

	// Offset binary is the clamped signed value with its top bit flipped
	always_comb begin
		quant_word = s_level[`AOP_WIDTH-1:0];
		if (over_pos) begin
			quant_word = aop_word_t'(`AOP_FS_POS);
		end else if (over_neg) begin
			quant_word = aop_word_t'(`AOP_FS_NEG);
		end
		quant_word[`AOP_WIDTH-1] = ~quant_word[`AOP_WIDTH-1];
	end

	assign link.advance = sample_edge; // [RL1]
	assign link.head_word = quant_word;
	assign link.head_flag = over_pos || over_neg; // [RL6]

	// Mode pins pick the state; software power down acts like the pin
	always_comb begin
		next_state = AOP_NORMAL; // [RL3]
		if (s_pd || ctrl_pd) begin
			next_state = s_oe_n ? AOP_SLEEP : AOP_NAP; // [RL4]
		end
		// Hold the decoded configuration unless a level below says otherwise
		next_twos = twos;
		next_stab = duty_stabilizer_on;
		unique case (s_mode) // [RL5]
			`AOP_MODE_GND: begin
				next_twos = 1'b0;
				next_stab = 1'b0;
			end
			`AOP_MODE_THIRD: begin
				next_twos = 1'b0;
				next_stab = 1'b1;
			end
			`AOP_MODE_TWO_THIRDS: begin
				next_twos = 1'b1;
				next_stab = 1'b1;
			end
			`AOP_MODE_SUPPLY: begin
				next_twos = 1'b1;
				next_stab = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= AOP_NORMAL;
			twos <= 1'b0;
			duty_stabilizer_on <= 1'b0;
		end else begin
			state <= next_state;
			twos <= next_twos;
			duty_stabilizer_on <= next_stab;
		end
	end

	// Output word follows the pipeline tail one sample edge later
	always_comb begin
		next_word_out = sample_word_out;
		next_flag = range_flag;
		if (sample_edge) begin
			// Bit 13 is the MSB; format applied at the port, not in the pipe
			next_word_out = link.tail_word; // [RL2] [RL7]
			next_word_out[`AOP_WIDTH-1] = link.tail_word[`AOP_WIDTH-1] ^ twos; // [RL8]
			next_flag = link.tail_flag; // [RL6]
		end
		// Drivers are on only in normal mode with enable low
		next_word_oe = (next_state == AOP_NORMAL) && !s_oe_n; // [RL3] [RL4]
		next_flag_oe = next_word_oe; // [RL3]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_word_out <= '0;
			range_flag <= 1'b0;
			sample_word_oe <= 1'b0;
			range_flag_oe <= 1'b0;
		end else begin
			sample_word_out <= next_word_out;
			range_flag <= next_flag;
			sample_word_oe <= next_word_oe;
			range_flag_oe <= next_flag_oe;
		end
	end

	// APB slave: answer is prepared in setup, so pready is high in every access phase
	always_comb begin
		next_ctrl_pd = ctrl_pd;
		next_pready = psel && !penable;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			next_prdata = 32'h0000_0000;
			unique case (paddr)
				`AOP_OFF_CTRL: begin
					next_prdata[`AOP_CTRL_PD_BIT] = ctrl_pd;
				end
				`AOP_OFF_STATUS: begin
					next_prdata[`AOP_ST_STATE_LSB +: 2] = state;
					next_prdata[`AOP_ST_TWOS_BIT] = twos;
					next_prdata[`AOP_ST_STAB_BIT] = duty_stabilizer_on;
					next_prdata[`AOP_ST_FLAG_BIT] = range_flag;
				end
				`AOP_OFF_DATA: begin
					next_prdata[`AOP_WIDTH-1:0] = sample_word_out;
					next_prdata[`AOP_DATA_FLAG_BIT] = range_flag;
				end
				default: begin
					// Unmapped offsets read zero and report an error
					next_pslverr = 1'b1;
				end
			endcase
		end
		// Write lands only at the completing edge of the access phase
		if (psel && penable && pready && pwrite && (paddr == `AOP_OFF_CTRL)) begin
			next_ctrl_pd = pwdata[`AOP_CTRL_PD_BIT]; // [RL4]
		end
		if (psel && penable) begin
			next_pslverr = pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_pd <= `AOP_CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl_pd <= next_ctrl_pd;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end
endmodule // aop_port

// ===== aop_port_properties.sv
// Concurrent checks on the converter output port pins and bus
`timescale 1ns/1ns
module aop_port_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sample_clk,
	input wire logic output_enable_n,
	input wire logic power_down_select,
	input wire logic [1:0] mode_level,
	input wire aop_pkg::aop_word_t sample_word_out,
	input wire logic sample_word_oe,
	input wire logic range_flag_oe,
	input wire logic duty_stabilizer_on
);
	// All checks share the bus clock and reset
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_oe_pair;
		range_flag_oe == sample_word_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("enables differ");

	property p_oe_off;
		output_enable_n [*6] |-> !sample_word_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driving while disabled");

	property p_pd_off;
		power_down_select [*6] |-> !sample_word_oe && !range_flag_oe;
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("driving in power down");

	// Six cycles covers the pin synchroniser and the output register
	property p_stab;
		$stable(mode_level) [*6] |-> duty_stabilizer_on == (mode_level inside {2'h1, 2'h2});
	endproperty
	a_stab: assert property (p_stab) else $error("stabilizer mismatch");

	// Word moves only after a sample edge; mode pin changes are left out of this check
	property p_hold;
		($stable(sample_clk) && $stable(mode_level) && $stable(sample_word_oe)) [*6]
			|-> $stable(sample_word_out);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed without sample");

	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready too long");

	property p_setup_ready;
		psel && !penable |=> pready;
	endproperty
	a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");

	property p_unmapped;
		psel && !penable && paddr > 12'h008 |=> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
endmodule // aop_port_properties

// ===== aop_capture_model.sv
// Far side capture logic: latches the output pins on each sample clock rise
`timescale 1ns/1ns
module aop_capture_model (
	input wire logic sample_clk,
	input wire aop_pkg::aop_word_t sample_word_out,
	input wire logic sample_word_oe,
	output aop_pkg::aop_word_t cap_word
);
	logic [13:0] last_word; // Last value really driven on the pins
	logic [13:0] pin_word; // A released bus shows no trustworthy level
	always_comb pin_word = sample_word_oe ? sample_word_out : ~last_word;
	// Capture on the same edge that starts the next sample
	always @(posedge sample_clk) begin
		cap_word <= pin_word;
		if (sample_word_oe) last_word <= sample_word_out;
	end
endmodule // aop_capture_model

// ===== aop_port_tb.sv
// Self-checking testbench for the converter output port
`timescale 1ns/1ns
`include "aop_cfg.svh"
module aop_port_tb;
	import aop_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic sample_clk, output_enable_n, power_down_select;
	logic sample_word_oe, range_flag, range_flag_oe, duty_stabilizer_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mode_level;
	aop_level_t sample_level;
	aop_word_t sample_word_out, cap_word;
	logic [14:0] e [16]; // Expected flag and word per sample
	aop_level_t lv [10] = '{0, 8191, 8192, -8192, -8193, 100, -1, 4660, -32768, 77};
	int fail_count = 0, total_checks = 0, cyc = 0;

	aop_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sample_clk, .sample_level, .output_enable_n, .power_down_select,
		.mode_level, .sample_word_out, .sample_word_oe, .range_flag, .range_flag_oe,
		.duty_stabilizer_on);
	aop_capture_model u_cap (.sample_clk, .sample_word_out, .sample_word_oe, .cap_word);

	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end

	// A hang counts as a mismatch
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			final_report;
		end
	end

	task automatic final_report;
		if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; an edge first so back to back calls never clash
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// One sample clock period, level held through the rising edge
	task automatic samp(input aop_level_t l);
		sample_level <= l;
		repeat (4) @(posedge pclk);
		sample_clk <= 1;
		repeat (6) @(posedge pclk);
		sample_clk <= 0;
	endtask

	function automatic logic [14:0] enc(input aop_level_t l, input logic tw);
		logic [13:0] w;
		w = l > 16'sd8191 ? 14'h3FFF : l < -16'sd8192 ? 14'h0000 : 14'(l + 16'sd8192);
		return {l > 16'sd8191 || l < -16'sd8192, w ^ {tw, 13'h0}};
	endfunction

	// Set the mode pins, then compare enable and reported state
	task automatic st(input logic pd, input logic oen, input logic [1:0] s);
		power_down_select <= pd;
		output_enable_n <= oen;
		repeat (5) @(posedge pclk);
		apb(0, `AOP_OFF_STATUS, 0);
		chk({sample_word_oe, rd[1:0]}, {s == 2'h0 && !oen, s});
	endtask

	initial begin
		{psel, penable, pwrite, sample_clk, output_enable_n, power_down_select} = 0;
		{paddr, pwdata, sample_level, mode_level, presetn} = 0;
		repeat (12) @(posedge pclk);
		chk({pready, pslverr, sample_word_oe, range_flag_oe, duty_stabilizer_on, range_flag,
			sample_word_out, prdata}, 64'h0);
		presetn <= 1;
		for (int m = 0; m < 4; m++) begin
			mode_level <= 2'(m);
			repeat (5) @(posedge pclk);
			apb(0, `AOP_OFF_STATUS, 0);
			chk({duty_stabilizer_on, rd}, {m[1] ^ m[0], 28'h0, m[1] ^ m[0], m[1], 2'h0});
		end
		for (int p = 0; p < 2; p++) begin
			mode_level <= p ? 2'h3 : 2'h0;
			for (int j = 0; j < 16; j++) begin
				e[j] = enc(lv[j % 10], p[0]);
				samp(lv[j % 10]);
				if (j >= 6) chk({range_flag_oe, range_flag, sample_word_out}, {1'b1, e[j-6]});
				if (j >= 7) chk(cap_word, e[j-7][13:0]);
			end
		end
		apb(0, `AOP_OFF_DATA, 0);
		chk(rd, {15'h0, e[9][14], 2'h0, e[9][13:0]});
		apb(0, 12'h00C, 0);
		chk({err, rd}, {1'b1, 32'h0});
		st(0, 1, 0);
		st(0, 0, 0);
		st(1, 0, 1);
		st(1, 1, 2);
		apb(1, `AOP_OFF_CTRL, 1);
		st(0, 0, 1);
		apb(0, `AOP_OFF_CTRL, 0);
		chk(rd, 1);
		apb(1, `AOP_OFF_CTRL, 0);
		st(0, 0, 0);
		final_report;
	end
endmodule // aop_port_tb

bind aop_port aop_port_properties u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
	.pslverr, .sample_clk, .output_enable_n, .power_down_select, .mode_level,
	.sample_word_out, .sample_word_oe, .range_flag_oe, .duty_stabilizer_on);
